// ### hw/slsr_pkg.sv
// package: register bank layout, field codes, phy indication and bus request types for the link status block
package slsr_pkg;

  // bank geometry
  localparam int BANK_REGS = 16;
  localparam int IDX_W = 4;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;

  // register indices within the bank
  localparam logic [IDX_W-1:0] IDX_STATUS = 4'h0;
  localparam logic [IDX_W-1:0] IDX_ERROR = 4'h1;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 4'h2;

  // default base (byte address) of the bank
  localparam logic [ADDR_W-1:0] BANK_BASE_DEF = 16'h0100;

  // status field positions
  localparam int DET_LSB = 0;
  localparam int SPD_LSB = 4;
  localparam int PWR_LSB = 8;
  localparam int FIELD_W = 4;

  // detection codes
  localparam logic [3:0] DET_NONE = 4'h0;
  localparam logic [3:0] DET_PRESENT = 4'h1;
  localparam logic [3:0] DET_LINKED = 4'h3;
  localparam logic [3:0] DET_OFFLINE = 4'h4;

  // speed codes
  localparam logic [3:0] SPD_NONE = 4'h0;
  localparam logic [3:0] SPD_GEN1 = 4'h1;

  // power state codes
  localparam logic [3:0] PWR_NONE = 4'h0;
  localparam logic [3:0] PWR_ACTIVE = 4'h1;
  localparam logic [3:0] PWR_PARTIAL = 4'h2;
  localparam logic [3:0] PWR_SLUMBER = 4'h6;

  // reset values
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] ERROR_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

  // raw phy indications as they arrive from the pins
  typedef struct packed {
    logic dev_present;
    logic phy_ready;
    logic phy_offline;
    logic gen1_rate;
    logic partial;
    logic slumber;
  } slsr_phy_s;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } slsr_req_s;

endpackage

// ### hw/slsr_sync.sv
// three-stage synchroniser with second/third agreement filter
`timescale 1ns/1ns
module slsr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // async in, filtered out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] out_reg;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      out_reg <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          out_reg[i] <= s3_reg[i];
        end
      end
    end
  end

  assign sync_out = out_reg;
endmodule // slsr_sync

// ### hw/slsr_encode.sv
// encodes synchronised phy indications into the three status fields
`timescale 1ns/1ns
module slsr_encode
  import slsr_pkg::*;
(
  // phy indications, already synchronised
  input wire slsr_pkg::slsr_phy_s phy,
  // encoded fields
  output logic [3:0] det_code,
  output logic [3:0] spd_code,
  output logic [3:0] pwr_code
);
  logic linked;

  assign linked = phy.dev_present && phy.phy_ready && !phy.phy_offline;

  always_comb begin
    // low power hides the device unless phy_offline is set: detection reads as absent [R12]
    if (phy.phy_offline) begin
      det_code = DET_OFFLINE; // [R8]
    end else if (phy.partial || phy.slumber) begin
      det_code = DET_NONE; // [R12]
    end else if (linked) begin
      det_code = DET_LINKED; // [R8]
    end else if (phy.dev_present) begin
      det_code = DET_PRESENT; // [R8]
    end else begin
      det_code = DET_NONE; // [R8]
    end
  end

  always_comb begin
    if (linked && phy.gen1_rate) begin
      spd_code = SPD_GEN1; // [R9]
    end else begin
      spd_code = SPD_NONE; // [R9]
    end
  end

  always_comb begin
    if (!linked) begin
      pwr_code = PWR_NONE; // [R10]
    end else if (phy.slumber) begin
      pwr_code = PWR_SLUMBER; // [R10]
    end else if (phy.partial) begin
      pwr_code = PWR_PARTIAL; // [R10]
    end else begin
      pwr_code = PWR_ACTIVE; // [R10]
    end
  end
endmodule // slsr_encode

// ### hw/slsr_regs.sv
// serial link status register bank: sixteen words, status live from phy
`timescale 1ns/1ns
// Summary of operation
// R1: sixteen contiguous 32-bit registers, separately mapped
// R2: only first three defined, rest reserved
// R3: index 0 status, 1 error, 2 control
// R4: bank base address is configurable
// R5: independent of drive select emulation state
// R6: status read-only; writes ignored
// R7: status reflects live state at read
// R8: detection field codes 0,1,3,4
// R9: speed field codes 0 and 1
// R10: power field codes 0,1,2,6
// R11: reserved status bits read zero
// R12: detection unreliable outside active power state
// R13: fields at 3:0, 7:4, 11:8
// R14: reserved locations read zero, writes ignored
module slsr_regs
  import slsr_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BANK_BASE = BANK_BASE_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register port
  input wire slsr_pkg::slsr_req_s req,
  output logic [DATA_W-1:0] rdata,
  // phy indications from pins
  input wire slsr_pkg::slsr_phy_s phy_pins,
  // control word to interface logic, error bits in from it
  output logic [DATA_W-1:0] link_control,
  input wire logic [DATA_W-1:0] error_set
);
  slsr_phy_s phy_sync;
  logic [3:0] det_code;
  logic [3:0] spd_code;
  logic [3:0] pwr_code;
  logic [DATA_W-1:0] status_reg;
  logic [DATA_W-1:0] error_reg;
  logic [DATA_W-1:0] control_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic in_bank;
  logic [IDX_W-1:0] idx;

  // decode: byte address within the bank, one aligned word each
  function automatic logic bank_hit(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - BANK_BASE;
    return (a >= BANK_BASE) && (off < ADDR_W'(BANK_REGS * 4))
      && (off[1:0] == 2'b00); // [R1] [R4]
  endfunction

  function automatic logic [IDX_W-1:0] bank_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - BANK_BASE;
    return off[IDX_W+1:2]; // [R3]
  endfunction

  assign in_bank = bank_hit(req.addr);
  assign idx = bank_idx(req.addr);

  slsr_sync #(
    .WIDTH($bits(slsr_phy_s))
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in(phy_pins),
    .sync_out(phy_sync)
  );

  slsr_encode u_encode (
    .phy(phy_sync),
    .det_code(det_code),
    .spd_code(spd_code),
    .pwr_code(pwr_code)
  );

  // status refreshed every cycle, no bus input reaches it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      status_reg <= STATUS_RST;
    end else begin
      status_reg <= '0; // [R11] [R7] [R5] [R6]
      status_reg[DET_LSB +: FIELD_W] <= det_code; // [R13]
      status_reg[SPD_LSB +: FIELD_W] <= spd_code; // [R13]
      status_reg[PWR_LSB +: FIELD_W] <= pwr_code; // [R13]
    end
  end

  // error bits: set wins over write-one-to-clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      error_reg <= ERROR_RST;
    end else if (req.wr && in_bank && idx == IDX_ERROR) begin
      error_reg <= (error_reg & ~req.wdata) | error_set;
    end else begin
      error_reg <= error_reg | error_set;
    end
  end

  // control holds the last value written
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      control_reg <= CONTROL_RST;
    end else if (req.wr && in_bank && idx == IDX_CONTROL) begin
      control_reg <= req.wdata;
    end
  end

  always_comb begin
    rdata_next = '0;
    if (req.rd && in_bank) begin
      unique case (idx)
        IDX_STATUS: rdata_next = status_reg; // [R7]
        IDX_ERROR: rdata_next = error_reg;
        IDX_CONTROL: rdata_next = control_reg;
        default: rdata_next = '0; // [R2] [R14]
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign link_control = control_reg;
endmodule // slsr_regs

// ### tb/slsr_regs_asserts.sv
// checker: bus and status relations of the link status register bank
`timescale 1ns/1ns
module slsr_regs_asserts
  import slsr_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BANK_BASE = BANK_BASE_DEF
) (
  // clock, reset and register port
  input wire logic clock,
  input wire logic reset,
  input wire slsr_pkg::slsr_req_s req,
  input wire logic [DATA_W-1:0] rdata,
  // pins and interface logic side
  input wire slsr_pkg::slsr_phy_s phy_pins,
  input wire logic [DATA_W-1:0] link_control,
  input wire logic [DATA_W-1:0] error_set
);
  import slsr_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  wire logic [ADDR_W-1:0] off = req.addr - BANK_BASE;
  wire logic st = req.rd && off == 16'h0000;
  wire logic cr = req.rd && off == 16'h0008;
  wire logic cw = req.wr && off == 16'h0008;
  wire logic rs = req.rd && off >= 16'h000c && off < 16'h0040;
  property p_idle; !req.rd |=> rdata == 32'h0; endproperty
  property p_rsv; rs |=> rdata == 32'h0; endproperty
  property p_hi; st |=> rdata[31:12] == 20'h0; endproperty
  property p_det; st |=> rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h4};
  endproperty
  property p_spd;
    st |=> rdata[7:4] == 4'h0 || rdata[7:4] == 4'h1 && rdata[11:8] != 4'h0;
  endproperty
  property p_pwr; st |=> rdata[11:8] inside {4'h0, 4'h1, 4'h2, 4'h6};
  endproperty
  property p_quiet;
    st |=> rdata[11:8] != 4'h2 && rdata[11:8] != 4'h6 || rdata[3:0] == 4'h0;
  endproperty
  property p_cw; cw |=> link_control == $past(req.wdata); endproperty
  property p_keep; !cw |=> $stable(link_control); endproperty
  property p_cr; cr |=> rdata == link_control; endproperty
  a_idle: assert property (p_idle) else $error("rdata not zero");
  a_rsv: assert property (p_rsv) else $error("reserved read");
  a_hi: assert property (p_hi) else $error("status high bits");
  a_det: assert property (p_det) else $error("detect code");
  a_spd: assert property (p_spd) else $error("speed code");
  a_pwr: assert property (p_pwr) else $error("power code");
  a_quiet: assert property (p_quiet) else $error("detect in low power");
  a_cw: assert property (p_cw) else $error("control write");
  a_keep: assert property (p_keep) else $error("control changed");
  a_cr: assert property (p_cr) else $error("control read");
  c_st: cover property (st);
  c_cw: cover property (cw);
  c_rs: cover property (rs);
endmodule // slsr_regs_asserts

bind slsr_regs slsr_regs_asserts #(.BANK_BASE(BANK_BASE)) u_chk (
  .clock(clock), .reset(reset), .req(req), .rdata(rdata),
  .phy_pins(phy_pins), .link_control(link_control), .error_set(error_set)
);

// ### tb/slsr_regs_tb.sv
// testbench: register bank reads, writes and live status
`timescale 1ns/1ns
module slsr_regs_tb;
  import slsr_pkg::*;
  localparam logic [ADDR_W-1:0] B = 16'h0400;
  logic clock = 1'b0;
  logic reset = 1'b1;
  slsr_req_s req = '0;
  slsr_phy_s phy_pins = '0;
  logic [DATA_W-1:0] error_set = '0;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] link_control;
  logic [5:0] pv [6] = '{6'h20, 6'h34, 6'h30, 6'h36, 6'h35, 6'h28};
  logic [31:0] sv [6] = '{32'h1, 32'h113, 32'h103, 32'h210, 32'h610, 32'h4};
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  slsr_regs #(.BANK_BASE(B)) dut (.clock(clock), .reset(reset), .req(req),
    .rdata(rdata), .phy_pins(phy_pins), .link_control(link_control),
    .error_set(error_set));
  always #10 clock = ~clock;
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  task automatic rd(logic [15:0] a, logic [31:0] e, string n);
    @(posedge clock);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 check(n, rdata, e);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    rd(B, 32'h0, "status idle");
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      phy_pins <= pv[i];
      repeat (8) @(posedge clock);
      rd(B, sv[i], "status word");
    end
    $display("status test done");
    wr(B, 32'hffff_ffff);
    rd(B, sv[5], "status after write");
    wr(B + 16'h8, 32'ha5a5_5a5a);
    #1 check("control out", link_control, 32'ha5a5_5a5a);
    for (int i = 3; i < 16; i++) begin
      wr(B + 16'(4 * i), 32'hffff_ffff);
      rd(B + 16'(4 * i), 32'h0, "reserved");
    end
    rd(B + 16'h8, 32'ha5a5_5a5a, "control kept");
    $display("bank test done");
    @(posedge clock);
    error_set <= 32'h0000_0101;
    @(posedge clock);
    error_set <= 32'h0;
    rd(B + 16'h4, 32'h0000_0101, "error set");
    wr(B + 16'h4, 32'h0000_0001);
    rd(B + 16'h4, 32'h0000_0100, "error clear");
    // clearing a bit in the cycle it is set again must keep it set
    @(posedge clock);
    req <= '{addr: B + 16'h4, wdata: 32'h0000_0100, wr: 1'b1, rd: 1'b0};
    error_set <= 32'h0000_0100;
    @(posedge clock);
    req.wr <= 1'b0;
    error_set <= 32'h0;
    rd(B + 16'h4, 32'h0000_0100, "error set wins");
    wr(B + 16'h4, 32'h0000_0100);
    rd(B + 16'h4, 32'h0000_0000, "error cleared");
    rd(16'h0100, 32'h0, "outside bank");
    @(posedge clock);
    reset <= 1'b1;
    @(posedge clock);
    reset <= 1'b0;
    rd(B + 16'h8, 32'h0, "control reset");
    $display("error and reset test done");
    summarize();
  end
endmodule // slsr_regs_tb
